/* File: hdl/fer_status_regs.sv */
// status, event and identification registers with their read port
//
// Summary of operation
// - Offset 00h holds event flags that reset to zero and clear on a read unless set on that edge, bit 0 marking an output-in-range change.
// - Event bit 1 latches an over-current event and reads zero after a clearing read unless it changes on that edge.
// - Event bit 2 latches an input under-voltage event and reads zero after a clearing read unless it changes on that edge.
// - Event bit 5 latches a heat pre-warning event and reads zero after a clearing read unless it changes on that edge.
// - Event bit 6 latches a heat warning event and reads zero after a clearing read unless it changes on that edge.
// - Event bit 7 latches a heat shutdown event and reads zero after a clearing read unless it changes on that edge.
// - Offset 01h is a read-only live copy of the conditions that resets to zero, bit 0 showing output in range.
// - Live bit 1 is one while the output current is above its limit.
// - Live bit 2 is one while the input voltage is below its threshold.
// - Live bit 5 is one while the junction is above the pre-warning limit.
// - Live bit 6 is one while the junction is above the warning limit.
// - Live bit 7 is one while the junction is above the shutdown limit.
// - Offset 04h returns a four-bit silicon revision in bits 3 to 0 with zero above.
// - Offset 05h returns a four-bit feature code in bits 3 to 0 with zero above.
`include "fer_defines.svh"

module fer_status_regs #(
   parameter fer_pkg::fer_byte_type   PRODUCT_CODE   =
      `FER_PRODUCT_CODE_DEF,            // arbitrary value
   parameter fer_pkg::fer_nibble_type REVISION_FIELD =
      `FER_REVISION_FIELD_DEF,          // arbitrary value
   parameter fer_pkg::fer_nibble_type FEATURE_FIELD  =
      `FER_FEATURE_FIELD_DEF            // arbitrary value
) (
   input  wire logic                  i_core_clk,          // core clock
   input  wire logic                  i_rst_n,             // sync reset
   input  wire logic                  i_ce,                // clock enable
   input  wire logic                  i_output_in_range,   // vout in range
   input  wire logic                  i_overcurrent,       // over limit
   input  wire logic                  i_input_low,         // vin low
   input  wire logic                  i_heat_prewarning,   // temp prewarn
   input  wire logic                  i_heat_warning,      // temp warn
   input  wire logic                  i_heat_shutdown,     // temp shutdown
   input  wire logic                  i_rd_en,             // read strobe
   input  wire logic                  i_wr_en,             // write strobe
   input  wire fer_pkg::fer_byte_type i_addr,              // reg offset
   input  wire fer_pkg::fer_byte_type i_wr_data,           // write data
   output fer_pkg::fer_byte_type      o_rd_data,           // read data
   output logic                       o_rd_valid,          // read done
   output fer_pkg::fer_byte_type      o_event_latch,       // event flags
   output fer_pkg::fer_byte_type      o_live_condition     // live status
);
   import fer_pkg::*;

   fer_top_state_type state_reg;
   fer_top_state_type state_next;
   fer_byte_type      cond;
   fer_byte_type      live;
   fer_byte_type      event_flags;
   fer_byte_type      edge_set;
   fer_byte_type      rd_mux;
   logic              rd_take;
   logic              clear_events;

   // offset compare, used by the clear, the mux and the checks
   function automatic logic fer_hit(input fer_byte_type addr,
                                    input fer_byte_type ofs);
      fer_hit = (addr == ofs);
   endfunction

   // identification byte: field in the low nibble, zeros above
   function automatic fer_byte_type fer_id_byte(input fer_nibble_type f);
      fer_id_byte = {`FER_ID_UPPER_ZERO, f};
   endfunction

   always_comb begin
      cond = '0;
      cond[`FER_OUTPUT_IN_RANGE_BIT] = i_output_in_range;
      cond[`FER_OVERCURRENT_BIT]     = i_overcurrent;
      cond[`FER_INPUT_LOW_BIT]       = i_input_low;
      cond[`FER_HEAT_PREWARNING_BIT] = i_heat_prewarning;
      cond[`FER_HEAT_WARNING_BIT]    = i_heat_warning;
      cond[`FER_HEAT_SHUTDOWN_BIT]   = i_heat_shutdown;
   end

   // a frozen clock enable also holds off the read and its clear
   assign rd_take      = i_ce & i_rd_en;
   assign clear_events = rd_take &
                         fer_hit(i_addr, `FER_EVENT_LATCH_OFS);

   fer_event_latch u_latch (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_ce       (i_ce),
      .i_cond     (cond),
      .i_clear    (clear_events),
      .o_live     (live),
      .o_event    (event_flags),
      .o_set      (edge_set)
   );

   always_comb begin
      rd_mux = `FER_UNMAPPED_READ;
      if (fer_hit(i_addr, `FER_EVENT_LATCH_OFS)) begin
         rd_mux = event_flags;
      end else if (fer_hit(i_addr, `FER_LIVE_CONDITION_OFS)) begin
         rd_mux = live;
      end else if (fer_hit(i_addr, `FER_PRODUCT_CODE_OFS)) begin
         rd_mux = PRODUCT_CODE;
      end else if (fer_hit(i_addr, `FER_SILICON_REVISION_OFS)) begin
         rd_mux = fer_id_byte(REVISION_FIELD);
      end else if (fer_hit(i_addr, `FER_FEATURE_CODE_OFS)) begin
         rd_mux = fer_id_byte(FEATURE_FIELD);
      end
   end

   // every register is read-only, so write data is deliberately dropped
   always_comb begin
      state_next          = state_reg;
      state_next.rd_valid = rd_take;
      if (rd_take) begin
         state_next.rd_data = rd_mux;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         state_reg.rd_data  <= `FER_UNMAPPED_READ;
         state_reg.rd_valid <= 1'b0;
      end else if (i_ce) begin
         state_reg <= state_next;
      end else begin
         // valid is a pulse even when the enable drops
         state_reg.rd_valid <= 1'b0;
      end
   end

   assign o_rd_data        = state_reg.rd_data;
   assign o_rd_valid       = state_reg.rd_valid;
   assign o_event_latch    = event_flags;
   assign o_live_condition = live;

   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_rst_n);

   sequence s_read_event;
      i_ce && i_rd_en && fer_hit(i_addr, `FER_EVENT_LATCH_OFS);
   endsequence

   sequence s_read_live;
      i_ce && i_rd_en && fer_hit(i_addr, `FER_LIVE_CONDITION_OFS);
   endsequence

   sequence s_write_product;
      i_ce && i_wr_en && fer_hit(i_addr, `FER_PRODUCT_CODE_OFS);
   endsequence

   sequence s_read_product;
      i_ce && i_rd_en && fer_hit(i_addr, `FER_PRODUCT_CODE_OFS);
   endsequence

   // no clearing read this cycle, so the flags may only grow
   sequence s_idle_enabled;
      i_ce && !clear_events;
   endsequence

   sequence s_frozen;
      !i_ce;
   endsequence

   AST_EVT_CLEAR: assert property (
      s_read_event ##0 (edge_set == 8'h00) |=> (event_flags == 8'h00))
      else $error("event latch not cleared by read");

   AST_EVT_READ_VALUE: assert property (
      s_read_event |=> o_rd_valid && (o_rd_data == $past(event_flags)))
      else $error("event read returned wrong value");

   AST_EVT_SET_WINS: assert property (
      s_read_event ##0 edge_set[`FER_OVERCURRENT_BIT]
      |=> event_flags[`FER_OVERCURRENT_BIT])
      else $error("overcurrent event lost at clear");

   AST_EVT_PG_RISE: assert property (
      (i_ce && i_output_in_range && !live[`FER_OUTPUT_IN_RANGE_BIT])
      |=> event_flags[`FER_OUTPUT_IN_RANGE_BIT])
      else $error("rising in-range change not latched");

   AST_EVT_UV_FALL: assert property (
      (i_ce && !i_input_low && live[`FER_INPUT_LOW_BIT])
      |=> event_flags[`FER_INPUT_LOW_BIT])
      else $error("falling input-low change not latched");

   AST_EVT_HEAT: assert property (
      (i_ce && (cond[7:5] != live[7:5])) |=> (event_flags[7:5] != 3'b000))
      else $error("heat change not latched");

   AST_EVT_HOLD: assert property (
      (i_ce && !i_rd_en && event_flags[`FER_HEAT_WARNING_BIT])
      |=> event_flags[`FER_HEAT_WARNING_BIT])
      else $error("heat warning event dropped without read");

   AST_EVT_SHUT_TWO_STEP: assert property (
      (i_ce && i_heat_shutdown && !live[`FER_HEAT_SHUTDOWN_BIT])
      ##1 (s_read_event ##0 !edge_set[`FER_HEAT_SHUTDOWN_BIT])
      |=> o_rd_data[`FER_HEAT_SHUTDOWN_BIT]
          && !event_flags[`FER_HEAT_SHUTDOWN_BIT])
      else $error("shutdown event not read then cleared");

   AST_LIVE_MIRROR: assert property (
      i_ce |=> (live == ($past(cond) & 8'hE7)))
      else $error("live condition does not follow inputs");

   AST_LIVE_READ: assert property (
      s_read_live |=> (o_rd_data == $past(live)))
      else $error("live read returned wrong value");

   AST_LIVE_THERMAL_STEADY: assert property (
      (i_ce && i_heat_prewarning)[*2]
      |-> live[`FER_HEAT_PREWARNING_BIT])
      else $error("prewarning not shown while present");

   AST_LIVE_WARN_CLEAR: assert property (
      (i_ce && !i_heat_warning)[*2] |-> !live[`FER_HEAT_WARNING_BIT])
      else $error("warning shown while absent");

   AST_LIVE_SHUT: assert property (
      (i_ce && i_heat_shutdown) ##1 (!i_ce)[*3]
      |-> live[`FER_HEAT_SHUTDOWN_BIT])
      else $error("shutdown live lost under frozen enable");

   AST_REV_READ: assert property (
      (i_ce && i_rd_en && fer_hit(i_addr, `FER_SILICON_REVISION_OFS))
      |=> (o_rd_data == {4'h0, REVISION_FIELD}))
      else $error("revision read wrong");

   AST_FEAT_READ: assert property (
      (i_ce && i_rd_en && fer_hit(i_addr, `FER_FEATURE_CODE_OFS))
      |=> (o_rd_data[7:4] == 4'h0) && (o_rd_data[3:0] == FEATURE_FIELD))
      else $error("feature read wrong");

   AST_SPARE_ZERO: assert property (
      (event_flags[4:3] == 2'b00) && (live[4:3] == 2'b00))
      else $error("spare bit set");

   AST_PRODUCT_WRITE: assert property (
      s_write_product ##[1:4] s_read_product
      |=> (o_rd_data == PRODUCT_CODE))
      else $error("product code changed by write");

   AST_RD_VALID_PULSE: assert property (
      !(i_ce && i_rd_en) |=> !o_rd_valid)
      else $error("read valid without read");

   AST_UNMAPPED: assert property (
      (i_ce && i_rd_en && (i_addr == 8'h02)) |=> (o_rd_data == 8'h00))
      else $error("reserved offset did not read zero");

   AST_EVT_ACCUMULATE: assert property (
      s_idle_enabled
      |=> (event_flags == ($past(event_flags) | $past(edge_set))))
      else $error("event flags did not accumulate changes");

   AST_EVT_CLEAR_EXACT: assert property (
      s_read_event
      |=> (event_flags == $past(edge_set)))
      else $error("read clear kept stale flags");

   AST_FROZEN_STATE: assert property (
      s_frozen
      |=> (event_flags == $past(event_flags)) && (live == $past(live)))
      else $error("state moved with enable low");

   AST_RD_DATA_HOLD: assert property (
      !(i_ce && i_rd_en)
      |=> (o_rd_data == $past(o_rd_data)))
      else $error("read data changed without a read");

   AST_RD_VALID_RISE: assert property (
      (i_ce && i_rd_en)
      |=> o_rd_valid)
      else $error("accepted read gave no valid");

   AST_PRODUCT_READ: assert property (
      s_read_product
      |=> (o_rd_data == PRODUCT_CODE))
      else $error("product code read wrong");

   AST_SPARE_NO_EDGE: assert property (
      i_ce
      |-> (edge_set[`FER_SPARE_HI_BIT:`FER_SPARE_LO_BIT] == 2'b00))
      else $error("spare bit produced an event");

   AST_EVT_RANGE_FALL: assert property (
      (i_ce && !i_output_in_range && live[`FER_OUTPUT_IN_RANGE_BIT])
      |=> event_flags[`FER_OUTPUT_IN_RANGE_BIT])
      else $error("falling in-range change not latched");

   AST_EVT_OC_EDGE: assert property (
      (i_ce && (i_overcurrent != live[`FER_OVERCURRENT_BIT]))
      |=> event_flags[`FER_OVERCURRENT_BIT])
      else $error("overcurrent change not latched");

   AST_EVT_UV_RISE: assert property (
      (i_ce && i_input_low && !live[`FER_INPUT_LOW_BIT])
      |=> event_flags[`FER_INPUT_LOW_BIT])
      else $error("rising input-low change not latched");

   AST_EVT_PREW_EDGE: assert property (
      (i_ce && (i_heat_prewarning != live[`FER_HEAT_PREWARNING_BIT]))
      |=> event_flags[`FER_HEAT_PREWARNING_BIT])
      else $error("prewarning change not latched");

   AST_EVT_WARN_EDGE: assert property (
      (i_ce && (i_heat_warning != live[`FER_HEAT_WARNING_BIT]))
      |=> event_flags[`FER_HEAT_WARNING_BIT])
      else $error("warning change not latched");

   AST_EVT_SHUT_EDGE: assert property (
      (i_ce && (i_heat_shutdown != live[`FER_HEAT_SHUTDOWN_BIT]))
      |=> event_flags[`FER_HEAT_SHUTDOWN_BIT])
      else $error("shutdown change not latched");

   AST_LIVE_IN_RANGE: assert property (
      i_ce
      |=> (live[`FER_OUTPUT_IN_RANGE_BIT] == $past(i_output_in_range)))
      else $error("in-range live bit wrong");

   AST_LIVE_OVERCURRENT: assert property (
      i_ce
      |=> (live[`FER_OVERCURRENT_BIT] == $past(i_overcurrent)))
      else $error("overcurrent live bit wrong");

   AST_LIVE_INPUT_LOW: assert property (
      i_ce
      |=> (live[`FER_INPUT_LOW_BIT] == $past(i_input_low)))
      else $error("input-low live bit wrong");

   AST_LIVE_PREWARNING: assert property (
      i_ce
      |=> (live[`FER_HEAT_PREWARNING_BIT] == $past(i_heat_prewarning)))
      else $error("prewarning live bit wrong");

   AST_LIVE_WARNING: assert property (
      i_ce
      |=> (live[`FER_HEAT_WARNING_BIT] == $past(i_heat_warning)))
      else $error("warning live bit wrong");

   AST_LIVE_SHUTDOWN: assert property (
      i_ce
      |=> (live[`FER_HEAT_SHUTDOWN_BIT] == $past(i_heat_shutdown)))
      else $error("shutdown live bit wrong");

endmodule

/* File: hdl/fer_defines.svh */
// offsets, field positions, reset values and id codes of the status group
`ifndef FER_DEFINES_SVH
`define FER_DEFINES_SVH

// register offsets
`define FER_EVENT_LATCH_OFS      8'h00
`define FER_LIVE_CONDITION_OFS   8'h01
`define FER_PRODUCT_CODE_OFS     8'h03
`define FER_SILICON_REVISION_OFS 8'h04
`define FER_FEATURE_CODE_OFS     8'h05

// bit positions shared by event latch and live condition
`define FER_OUTPUT_IN_RANGE_BIT  0
`define FER_OVERCURRENT_BIT      1
`define FER_INPUT_LOW_BIT        2
`define FER_SPARE_LO_BIT         3
`define FER_SPARE_HI_BIT         4
`define FER_HEAT_PREWARNING_BIT  5
`define FER_HEAT_WARNING_BIT     6
`define FER_HEAT_SHUTDOWN_BIT    7

// bits that carry a condition; bits 4 and 3 stay zero
`define FER_IMPLEMENTED_MASK     8'hE7

// reset values and constant read values
`define FER_EVENT_LATCH_RST      8'h00
`define FER_LIVE_CONDITION_RST   8'h00
`define FER_UNMAPPED_READ        8'h00
`define FER_ID_UPPER_ZERO        4'h0

// position of the top bit of the product code
`define FER_PRODUCT_CODE_MSB     7

// identification defaults, values are arbitrary
`define FER_PRODUCT_CODE_DEF     8'h5A
`define FER_REVISION_FIELD_DEF   4'h3
`define FER_FEATURE_FIELD_DEF    4'h2

`endif

/* File: hdl/fer_pkg.sv */
// types of the fault event and identification register group
package fer_pkg;

   typedef logic [7:0] fer_byte_type;
   typedef logic [3:0] fer_nibble_type;

   // state of the event latch leaf
   typedef struct packed {
      fer_byte_type live;
      fer_byte_type event_latch;
   } fer_latch_state_type;

   // state of the register read path
   typedef struct packed {
      fer_byte_type rd_data;
      logic         rd_valid;
   } fer_top_state_type;

endpackage

/* File: hdl/fer_event_latch.sv */
// live condition sampling and dual-edge read-to-clear event latch
`include "fer_defines.svh"

module fer_event_latch (
   input  wire logic                i_core_clk, // core clock
   input  wire logic                i_rst_n,    // sync reset, active low
   input  wire logic                i_ce,       // clock enable
   input  wire fer_pkg::fer_byte_type i_cond,   // raw conditions
   input  wire logic                i_clear,    // read of event latch
   output fer_pkg::fer_byte_type    o_live,     // live condition reg
   output fer_pkg::fer_byte_type    o_event,    // event latch reg
   output fer_pkg::fer_byte_type    o_set       // edges seen this cycle
);
   import fer_pkg::*;

   fer_latch_state_type state_reg;
   fer_latch_state_type state_next;
   fer_byte_type        cond_masked;
   fer_byte_type        edge_set;

   always_comb begin
      // spare bits are masked so they can never be set
      cond_masked = i_cond & `FER_IMPLEMENTED_MASK;
      // any change of a condition, rising or falling, is an event
      edge_set    = cond_masked ^ state_reg.live;
      state_next  = state_reg;
      state_next.live = cond_masked;
      // set wins over the read clear so no edge is lost
      state_next.event_latch = (i_clear ? `FER_EVENT_LATCH_RST
                                        : state_reg.event_latch)
                               | edge_set;
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         state_reg.live        <= `FER_LIVE_CONDITION_RST;
         state_reg.event_latch <= `FER_EVENT_LATCH_RST;
      end else if (i_ce) begin
         state_reg <= state_next;
      end
   end

   assign o_live  = state_reg.live;
   assign o_event = state_reg.event_latch;
   assign o_set   = edge_set;

endmodule

/* File: tb/fer_host_model.sv */
// host side model issuing reads and writes on the register strobe port
module fer_host_model (
   input  wire logic                  i_core_clk, // core clock
   input  wire logic                  i_rd_valid, // read done
   input  wire fer_pkg::fer_byte_type i_rd_data,  // read data
   output fer_pkg::fer_byte_type      o_addr,     // register offset
   output fer_pkg::fer_byte_type      o_wr_data,  // write data
   output logic                       o_rd_en,    // read strobe
   output logic                       o_wr_en     // write strobe
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      o_addr    = 8'hFF;
      o_wr_data = 8'h00;
      o_rd_en   = 1'b0;
      o_wr_en   = 1'b0;
   end

   // one strobe cycle, then wait a few falling edges for the answer
   task automatic read(input fer_pkg::fer_byte_type ofs,
                       output fer_pkg::fer_byte_type data,
                       output logic ok);
      int n;
      ok = 1'b0;
      data = 8'h00;
      @(negedge i_core_clk);
      o_addr = ofs;
      o_rd_en = 1'b1;
      @(negedge i_core_clk);
      o_rd_en = 1'b0;
      // a released offset must not keep looking valid
      o_addr = ~ofs;
      for (n = 0; n < 4 && ok !== 1'b1; n++) begin
         if (i_rd_valid === 1'b1) begin
            ok = 1'b1;
            data = i_rd_data;
         end else begin
            @(negedge i_core_clk);
         end
      end
   endtask

   task automatic write(input fer_pkg::fer_byte_type ofs,
                        input fer_pkg::fer_byte_type data);
      @(negedge i_core_clk);
      o_addr = ofs;
      o_wr_data = data;
      o_wr_en = 1'b1;
      @(negedge i_core_clk);
      o_wr_en = 1'b0;
      o_addr = ~ofs;
      o_wr_data = ~data;
   endtask
endmodule

/* File: tb/tb_top.sv */
// self-checking bench of the status, event and identification registers
`include "fer_defines.svh"

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import fer_pkg::*;

   logic         i_core_clk;
   logic         i_rst_n;
   logic         i_ce;
   logic [5:0]   cond;
   logic         rd_en;
   logic         wr_en;
   fer_byte_type addr;
   fer_byte_type wr_data;
   fer_byte_type rd_data;
   logic         rd_valid;
   fer_byte_type ev;
   fer_byte_type live;
   int           mismatches;
   int           num_checks;
   int           k;
   // register bit of each condition input, lowest input first
   localparam int BITPOS [6] = '{0, 1, 2, 5, 6, 7};

   fer_status_regs dut (
      .i_core_clk       (i_core_clk),
      .i_rst_n          (i_rst_n),
      .i_ce             (i_ce),
      .i_output_in_range(cond[0]),
      .i_overcurrent    (cond[1]),
      .i_input_low      (cond[2]),
      .i_heat_prewarning(cond[3]),
      .i_heat_warning   (cond[4]),
      .i_heat_shutdown  (cond[5]),
      .i_rd_en          (rd_en),
      .i_wr_en          (wr_en),
      .i_addr           (addr),
      .i_wr_data        (wr_data),
      .o_rd_data        (rd_data),
      .o_rd_valid       (rd_valid),
      .o_event_latch    (ev),
      .o_live_condition (live)
   );

   fer_host_model host (
      .i_core_clk(i_core_clk),
      .i_rd_valid(rd_valid),
      .i_rd_data (rd_data),
      .o_addr    (addr),
      .o_wr_data (wr_data),
      .o_rd_en   (rd_en),
      .o_wr_en   (wr_en)
   );

   initial begin
      i_core_clk = 1'b0;
      forever #10 i_core_clk = ~i_core_clk;
   end

   task automatic check(input fer_byte_type got, input fer_byte_type exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_rd(input fer_byte_type ofs, input fer_byte_type exp);
      fer_byte_type d;
      logic         ok;
      host.read(ofs, d, ok);
      check({7'h00, ok}, 8'h01);
      check(d, exp);
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(negedge i_core_clk);
   endtask

   task automatic give_verdict;
      if (mismatches == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // the whole sequence needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge i_core_clk);
      mismatches++;
      give_verdict();
   end

   initial begin
      fer_byte_type d;
      fer_byte_type one_hot;
      logic         ok;
      mismatches = 0;
      num_checks = 0;
      i_rst_n = 1'b0;
      i_ce = 1'b1;
      cond = 6'h00;
      repeat (16) @(negedge i_core_clk);
      i_rst_n = 1'b1;
      wait_cyc(2);
      check(ev, 8'h00);
      check(live, 8'h00);
      chk_rd(`FER_EVENT_LATCH_OFS, 8'h00);
      chk_rd(`FER_LIVE_CONDITION_OFS, 8'h00);
      chk_rd(`FER_PRODUCT_CODE_OFS, `FER_PRODUCT_CODE_DEF);
      host.write(`FER_PRODUCT_CODE_OFS, ~`FER_PRODUCT_CODE_DEF);
      chk_rd(`FER_PRODUCT_CODE_OFS, `FER_PRODUCT_CODE_DEF);
      chk_rd(`FER_SILICON_REVISION_OFS, {4'h0, `FER_REVISION_FIELD_DEF});
      chk_rd(`FER_FEATURE_CODE_OFS, {4'h0, `FER_FEATURE_FIELD_DEF});
      chk_rd(8'h02, `FER_UNMAPPED_READ);
      chk_rd(8'h06, `FER_UNMAPPED_READ);
      for (k = 0; k < 6; k++) begin
         one_hot = 8'h01 << BITPOS[k];
         // read in the cycle right after the rise, while the flag is fresh
         cond[k] = 1'b1;
         chk_rd(`FER_EVENT_LATCH_OFS, one_hot);
         chk_rd(`FER_LIVE_CONDITION_OFS, one_hot);
         chk_rd(`FER_EVENT_LATCH_OFS, 8'h00);
         cond[k] = 1'b0;
         wait_cyc(2);
         chk_rd(`FER_EVENT_LATCH_OFS, one_hot);
         chk_rd(`FER_LIVE_CONDITION_OFS, 8'h00);
         chk_rd(`FER_EVENT_LATCH_OFS, 8'h00);
      end
      cond = 6'h3F;
      wait_cyc(2);
      check(live, `FER_IMPLEMENTED_MASK);
      chk_rd(`FER_LIVE_CONDITION_OFS, 8'hE7);
      chk_rd(`FER_EVENT_LATCH_OFS, 8'hE7);
      check(ev, 8'h00);
      i_ce = 1'b0;
      host.read(`FER_LIVE_CONDITION_OFS, d, ok);
      check({7'h00, ok}, 8'h00);
      i_ce = 1'b1;
      cond[0] = 1'b0;
      wait_cyc(2);
      // a change on the clearing edge must survive the clear
      fork
         host.read(`FER_EVENT_LATCH_OFS, d, ok);
         begin
            @(negedge i_core_clk);
            cond[1] = 1'b0;
         end
      join
      check(d, 8'h01);
      chk_rd(`FER_EVENT_LATCH_OFS, 8'h02);
      chk_rd(`FER_LIVE_CONDITION_OFS, 8'hE4);
      // conditions fall and reset lands on the same edge, so nothing latches
      wait_cyc(2);
      cond = 6'h00;
      i_rst_n = 1'b0;
      repeat (16) @(negedge i_core_clk);
      i_rst_n = 1'b1;
      wait_cyc(2);
      chk_rd(`FER_EVENT_LATCH_OFS, 8'h00);
      chk_rd(`FER_LIVE_CONDITION_OFS, 8'h00);
      give_verdict();
   end
endmodule
